// [hdl/cycle_counter_va_control_regs.sv]
`timescale 1ns/10ps
// Overview of operation
// - enable bit 32 increments low half each cycle
// - upper half is plain non-counting storage
// - counter write updates upper half only
// - read counter instruction returns all 64 bits
// - control write loads counter bits 31:4
// - control write clears counter bits 3:0
// - translation miss or fault captures address
// - page table entry load never captures
// - format control keeps page table base 63:30
// - bit 2 selects 32-bit formatting variant
// - bit 1 selects 43 or 48 bit format
// - sign extension mismatch raises access violation
// - wide address mode resets to zero
// - swap bit inverts three-bit shift amount
// - swap bit inverts low address bits by size
module cycle_counter_va_control_regs (
   // clock and reset
   input wire logic clk_sys_i,
   input wire logic srst_i,
   // privileged register moves
   input wire logic priv_register_write_i,
   input wire logic [1:0] priv_sel_i,
   input wire logic [63:0] priv_wdata_i,
   input wire logic priv_register_read_i,
   output logic [63:0] priv_rdata_o,
   output logic priv_rvalid_o,
   // read cycle count instruction
   input wire logic read_cycle_count_instr_i,
   output logic [63:0] cycle_count_o,
   output logic cycle_count_valid_o,
   // memory pipe
   input wire logic mem_valid_i,
   input wire logic [63:0] mem_eff_addr_i,
   input wire logic data_translation_buffer_miss_i,
   input wire logic data_translation_fault_i,
   input wire logic page_table_entry_load_i,
   input wire logic [2:0] mem_phys_low_i,
   input wire cc_va_pkg::access_size_t mem_size_i,
   output logic access_violation_fault_o,
   output logic [2:0] mem_phys_low_o,
   // byte extract, insert and mask shift amount
   input wire logic [2:0] byte_shift_i,
   output logic [2:0] byte_shift_o,
   // control state views
   output logic [63:0] fault_virtual_address_o,
   output logic [33:0] page_table_base_o,
   output logic thirty_two_bit_format_o,
   output logic wide_address_mode_o
);
   import cc_va_pkg::*;

   logic [31:0] cc_upper;
   logic [31:0] cc_lower;
   logic count_enable_bit;
   logic [63:0] address_format_control;
   logic [63:0] fault_virtual_address;
   logic violation;
   logic wr_cc;
   logic wr_ctl;
   logic wr_fmt;
   logic swap;
   logic [2:0] next_phys_low;

   assign wr_cc = priv_register_write_i && priv_sel_i == SEL_CYCLE_COUNTER;
   assign wr_ctl = priv_register_write_i &&
                   priv_sel_i == SEL_CYCLE_COUNT_CONTROL;
   assign wr_fmt = priv_register_write_i &&
                   priv_sel_i == SEL_ADDRESS_FORMAT_CONTROL;
   assign swap = address_format_control[BYTE_ORDER_SWAP];

   // ***************************************
   // cycle counter
   // ***************************************
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         cc_upper <= COUNTER_RESET;
      end else if (wr_cc) begin
         cc_upper <= priv_wdata_i[63:32];
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         count_enable_bit <= 1'b0;
      end else if (wr_ctl) begin
         count_enable_bit <= priv_wdata_i[COUNT_ENABLE_BIT];
      end
   end

   // control write wins over the increment in the same cycle
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         cc_lower <= COUNTER_RESET;
      end else if (wr_ctl) begin
         cc_lower <= {priv_wdata_i[COUNTER_LOAD_HI:COUNTER_LOAD_LO],
                      4'h0};
      end else if (count_enable_bit) begin
         cc_lower <= cc_lower + 32'h1;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         cycle_count_o <= 64'h0;
         cycle_count_valid_o <= 1'b0;
      end else begin
         cycle_count_valid_o <= read_cycle_count_instr_i;
         if (read_cycle_count_instr_i) begin
            cycle_count_o <= {cc_upper, cc_lower};
         end
      end
   end

   // ***************************************
   // address format control
   // ***************************************
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         address_format_control <= ADDRESS_FORMAT_RESET;
      end else if (wr_fmt) begin
         address_format_control <= priv_wdata_i;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         page_table_base_o <= 34'h0;
         thirty_two_bit_format_o <= 1'b0;
         wide_address_mode_o <= 1'b0;
      end else begin
         page_table_base_o <= address_format_control[
                              PAGE_TABLE_BASE_HI:PAGE_TABLE_BASE_LO];
         thirty_two_bit_format_o <=
            address_format_control[THIRTY_TWO_BIT_FORMAT];
         wide_address_mode_o <=
            address_format_control[WIDE_ADDRESS_MODE];
      end
   end

   // ***************************************
   // fault virtual address
   // ***************************************
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         fault_virtual_address <= FAULT_VA_RESET;
      end else if (mem_valid_i && !page_table_entry_load_i &&
                   (data_translation_buffer_miss_i ||
                    data_translation_fault_i)) begin
         fault_virtual_address <= mem_eff_addr_i;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         fault_virtual_address_o <= FAULT_VA_RESET;
      end else begin
         fault_virtual_address_o <= fault_virtual_address;
      end
   end

   // ***************************************
   // privileged reads
   // ***************************************
   // write-only registers read as zero
   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         priv_rdata_o <= 64'h0;
         priv_rvalid_o <= 1'b0;
      end else begin
         priv_rvalid_o <= priv_register_read_i;
         if (priv_register_read_i) begin
            case (priv_sel_i)
               SEL_CYCLE_COUNTER: priv_rdata_o <= {cc_upper, cc_lower};
               SEL_FAULT_VIRTUAL_ADDRESS: begin
                  priv_rdata_o <= fault_virtual_address;
               end
               default: priv_rdata_o <= 64'h0;
            endcase
         end
      end
   end

   // ***************************************
   // sign extension check
   // ***************************************
   va_sign_check u_sign_check (
      .eff_addr_i(mem_eff_addr_i),
      .wide_mode_i(address_format_control[WIDE_ADDRESS_MODE]),
      .violation_o(violation)
   );

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         access_violation_fault_o <= 1'b0;
      end else begin
         access_violation_fault_o <= mem_valid_i && violation;
      end
   end

   // ***************************************
   // byte order swap
   // ***************************************
   always_comb begin
      next_phys_low = mem_phys_low_i;
      if (swap) begin
         case (mem_size_i)
            SIZE_BYTE: next_phys_low = mem_phys_low_i ^ 3'h7;
            SIZE_WORD: next_phys_low = mem_phys_low_i ^ 3'h6;
            SIZE_LONG: next_phys_low = mem_phys_low_i ^ 3'h4;
            default: next_phys_low = mem_phys_low_i;
         endcase
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (srst_i) begin
         mem_phys_low_o <= 3'h0;
         byte_shift_o <= 3'h0;
      end else begin
         mem_phys_low_o <= next_phys_low;
         byte_shift_o <= swap ? ~byte_shift_i : byte_shift_i;
      end
   end

   // ***************************************
   // assertions
   // ***************************************
   property p_count_inc;
      @(posedge clk_sys_i) disable iff (srst_i)
      (count_enable_bit && !wr_ctl) |=> cc_lower == $past(cc_lower) + 32'h1;
   endproperty
   a_count_inc: assert property (p_count_inc)
      else $error("counter did not increment");

   property p_upper_hold;
      @(posedge clk_sys_i) disable iff (srst_i)
      !wr_cc |=> $stable(cc_upper);
   endproperty
   a_upper_hold: assert property (p_upper_hold)
      else $error("upper half changed without write");

   property p_cc_write;
      @(posedge clk_sys_i) disable iff (srst_i)
      (wr_cc && !wr_ctl && !count_enable_bit) |=>
         cc_upper == $past(priv_wdata_i[63:32]) && $stable(cc_lower);
   endproperty
   a_cc_write: assert property (p_cc_write)
      else $error("counter write wrong");

   property p_read_cycle_count_instr;
      @(posedge clk_sys_i) disable iff (srst_i)
      read_cycle_count_instr_i |=> cycle_count_valid_o &&
         cycle_count_o == {$past(cc_upper), $past(cc_lower)};
   endproperty
   a_read_cycle_count_instr: assert property (p_read_cycle_count_instr)
      else $error("read count value wrong");

   property p_ctl_load;
      @(posedge clk_sys_i) disable iff (srst_i)
      wr_ctl |=> cc_lower == {$past(priv_wdata_i[31:4]), 4'h0};
   endproperty
   a_ctl_load: assert property (p_ctl_load)
      else $error("control write load wrong");

   sequence s_fault;
      mem_valid_i && !page_table_entry_load_i &&
      (data_translation_buffer_miss_i || data_translation_fault_i);
   endsequence
   property p_capture;
      @(posedge clk_sys_i) disable iff (srst_i)
      s_fault |=> fault_virtual_address == $past(mem_eff_addr_i)
              ##1 fault_virtual_address_o == $past(mem_eff_addr_i, 2);
   endproperty
   a_capture: assert property (p_capture)
      else $error("fault address not captured");

   property p_pte_skip;
      @(posedge clk_sys_i) disable iff (srst_i)
      page_table_entry_load_i |=> $stable(fault_virtual_address);
   endproperty
   a_pte_skip: assert property (p_pte_skip)
      else $error("pte load overwrote fault address");

   property p_acv;
      @(posedge clk_sys_i) disable iff (srst_i)
      (mem_valid_i && !wide_address_mode_o && !wr_fmt && $stable(
       address_format_control) && mem_eff_addr_i[63:42] != 22'h0 &&
       mem_eff_addr_i[63:42] != 22'h3fffff) |=> access_violation_fault_o;
   endproperty
   a_acv: assert property (p_acv)
      else $error("narrow sign violation missed");

   property p_shift;
      @(posedge clk_sys_i) disable iff (srst_i)
      swap |=> byte_shift_o == ~$past(byte_shift_i);
   endproperty
   a_shift: assert property (p_shift)
      else $error("shift not inverted");

   // without swap the amount must pass through untouched
   property p_shift_keep;
      @(posedge clk_sys_i) disable iff (srst_i)
      !swap |=> byte_shift_o == $past(byte_shift_i);
   endproperty
   a_shift_keep: assert property (p_shift_keep)
      else $error("shift changed without swap");
endmodule

// [hdl/cc_va_pkg.sv]
package cc_va_pkg;
   // register select codes on the privileged move port
   localparam logic [1:0] SEL_CYCLE_COUNTER = 2'h0;
   localparam logic [1:0] SEL_CYCLE_COUNT_CONTROL = 2'h1;
   localparam logic [1:0] SEL_ADDRESS_FORMAT_CONTROL = 2'h2;
   localparam logic [1:0] SEL_FAULT_VIRTUAL_ADDRESS = 2'h3;
   // cycle count control fields
   localparam int COUNT_ENABLE_BIT = 32;
   localparam int COUNTER_LOAD_HI = 31;
   localparam int COUNTER_LOAD_LO = 4;
   // address format control fields
   localparam int PAGE_TABLE_BASE_HI = 63;
   localparam int PAGE_TABLE_BASE_LO = 30;
   localparam int THIRTY_TWO_BIT_FORMAT = 2;
   localparam int WIDE_ADDRESS_MODE = 1;
   localparam int BYTE_ORDER_SWAP = 0;
   // sign extension source bit per address format
   localparam int NARROW_SIGN_BIT = 42;
   localparam int WIDE_SIGN_BIT = 47;
   // reset values
   localparam logic [63:0] ADDRESS_FORMAT_RESET = 64'h0;
   localparam logic [31:0] COUNTER_RESET = 32'h0;
   localparam logic [63:0] FAULT_VA_RESET = 64'h0;
   // data stream access size
   typedef enum logic [1:0] {
      SIZE_BYTE,
      SIZE_WORD,
      SIZE_LONG,
      SIZE_QUAD
   } access_size_t;
endpackage

// [hdl/va_sign_check.sv]
`timescale 1ns/10ps
// sign extension checker, combinational
module va_sign_check (
   // address under test
   input wire logic [63:0] eff_addr_i,
   input wire logic wide_mode_i,
   // result
   output logic violation_o
);
   import cc_va_pkg::*;

   function automatic logic sext_mismatch(input logic [63:0] a,
                                          input int top);
      logic [63:0] upper;
      upper = a >> top;
      return !((upper == 64'h0) || (upper == ({64{1'b1}} >> top)));
   endfunction

   always_comb begin
      if (wide_mode_i) begin
         violation_o = sext_mismatch(eff_addr_i, WIDE_SIGN_BIT);
      end else begin
         violation_o = sext_mismatch(eff_addr_i, NARROW_SIGN_BIT);
      end
   end
endmodule

// [tb/priv_pipe_model.sv]
`timescale 1ns/10ps
// ******
// instruction pipeline issuing register moves
// ******
module priv_pipe_model (
   // clock
   input wire logic clk_sys_i,
   // requests
   output logic wr_o,
   output logic rd_o,
   output logic rcc_o,
   output logic [1:0] sel_o,
   output logic [63:0] wdata_o,
   // answers
   input wire logic [63:0] rdata_i,
   input wire logic rvalid_i,
   input wire logic [63:0] count_i,
   input wire logic count_valid_i
);
   initial begin
      wr_o = 1'b0;
      rd_o = 1'b0;
      rcc_o = 1'b0;
      sel_o = 2'h0;
      wdata_o = 64'h0;
   end
   // kind 0 write, 1 read, 2 read count; at is the launch time
   task automatic req(input int kind, input logic [1:0] sel,
                      input logic [63:0] d, output logic [63:0] q,
                      output longint at);
      int n;
      @(posedge clk_sys_i);
      #1;
      at = $time;
      sel_o = sel;
      wdata_o = d;
      wr_o = (kind == 0);
      rd_o = (kind == 1);
      rcc_o = (kind == 2);
      @(posedge clk_sys_i);
      #1;
      wr_o = 1'b0;
      rd_o = 1'b0;
      rcc_o = 1'b0;
      // released lines show inverted data so stale values never match
      sel_o = ~sel;
      wdata_o = ~d;
      q = 'x;
      n = 0;
      while (kind != 0 && n < 4) begin
         if (kind == 1 && rvalid_i === 1'b1) begin
            q = rdata_i;
            n = 4;
         end else if (kind == 2 && count_valid_i === 1'b1) begin
            q = count_i;
            n = 4;
         end else begin
            @(posedge clk_sys_i);
            #1;
            n++;
         end
      end
   endtask
endmodule

// [tb/cycle_counter_va_control_regs_test.sv]
`timescale 1ns/10ps
module cycle_counter_va_control_regs_test;
   import cc_va_pkg::*;
   logic clk = 1'b0, srst = 1'b1, wr, rd, rcc, rvalid, cnt_v, mv, miss;
   logic flt, pte, avf, f32, wide;
   logic [1:0] sel;
   logic [2:0] pl_i = 3'h0, pl_o, sh_i = 3'h0, sh_o;
   logic [63:0] wd, rdata, cnt, addr = 64'h0, fva, q, v;
   logic [33:0] ptb;
   access_size_t size = SIZE_BYTE;
   longint t1, t2;
   int fails = 0, cmp_count = 0, cyc = 0;
   always #5 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 4000) begin
         fails = fails + 1;
         final_report();
      end
   end
   priv_pipe_model PIPE (.clk_sys_i(clk), .wr_o(wr), .rd_o(rd),
      .rcc_o(rcc), .sel_o(sel), .wdata_o(wd), .rdata_i(rdata),
      .rvalid_i(rvalid), .count_i(cnt), .count_valid_i(cnt_v));
   cycle_counter_va_control_regs DUT (.clk_sys_i(clk), .srst_i(srst),
      .priv_register_write_i(wr), .priv_sel_i(sel), .priv_wdata_i(wd),
      .priv_register_read_i(rd), .priv_rdata_o(rdata),
      .priv_rvalid_o(rvalid), .read_cycle_count_instr_i(rcc),
      .cycle_count_o(cnt), .cycle_count_valid_o(cnt_v),
      .mem_valid_i(mv), .mem_eff_addr_i(addr),
      .data_translation_buffer_miss_i(miss),
      .data_translation_fault_i(flt), .page_table_entry_load_i(pte),
      .mem_phys_low_i(pl_i), .mem_size_i(size),
      .access_violation_fault_o(avf), .mem_phys_low_o(pl_o),
      .byte_shift_i(sh_i), .byte_shift_o(sh_o),
      .fault_virtual_address_o(fva), .page_table_base_o(ptb),
      .thirty_two_bit_format_o(f32), .wide_address_mode_o(wide));
   // ******
   // shared tasks
   // ******
   task automatic chk(input string nm, input logic [63:0] e, g);
      cmp_count++;
      if (g !== e) begin
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
         fails++;
      end
   endtask
   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic mem(input logic [63:0] a, input logic m, f, p);
      tick(1);
      addr = a;
      miss = m;
      flt = f;
      pte = p;
      mv = 1'b1;
      tick(1);
      mv = 1'b0;
      miss = 1'b0;
      flt = 1'b0;
      pte = 1'b0;
      addr = ~a;
   endtask
   task automatic final_report();
      $display("mismatches %0d compares %0d", fails, cmp_count);
      if (fails == 0 && cmp_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   // ******
   // scenarios
   // ******
   task automatic t_counter();
      logic [31:0] e;
      PIPE.req(0, SEL_CYCLE_COUNT_CONTROL, 64'h0_abcd_123f, q, t1);
      PIPE.req(2, 2'h0, 64'h0, q, t1);
      chk("load", 64'habcd1230, q);
      PIPE.req(0, SEL_CYCLE_COUNTER, 64'h12345678_ffffffff, q, t1);
      PIPE.req(2, 2'h0, 64'h0, q, t1);
      chk("full", 64'h12345678_abcd1230, q);
      PIPE.req(0, SEL_CYCLE_COUNT_CONTROL, 64'h1_ffff_ffe9, q, t1);
      PIPE.req(2, 2'h0, 64'h0, q, t1);
      tick(40);
      PIPE.req(2, 2'h0, 64'h0, v, t2);
      e = q[31:0] + 32'((t2 - t1) / 10);
      chk("lower", {32'h0, e}, {32'h0, v[31:0]});
      chk("upper", 64'h12345678, {32'h0, v[63:32]});
      PIPE.req(0, SEL_CYCLE_COUNT_CONTROL, 64'h0, q, t1);
      $display("counter test done");
   endtask
   task automatic t_fault();
      mem(64'h00000123_456789a8, 1'b1, 1'b0, 1'b0);
      tick(3);
      chk("capture", 64'h00000123_456789a8, fva);
      PIPE.req(1, SEL_FAULT_VIRTUAL_ADDRESS, 64'h0, q, t1);
      chk("va read", 64'h00000123_456789a8, q);
      mem(64'h0000_0200_0000_0040, 1'b0, 1'b1, 1'b1);
      tick(3);
      chk("pte load", 64'h00000123_456789a8, fva);
      mem(64'hffff_fc00_0000_1000, 1'b0, 1'b1, 1'b0);
      tick(3);
      chk("fault", 64'hffff_fc00_0000_1000, fva);
      $display("fault address test done");
   endtask
   task automatic t_format();
      v = 64'hdeadbeef_c0000006;
      PIPE.req(0, SEL_ADDRESS_FORMAT_CONTROL, v, q, t1);
      tick(2);
      chk("base", 64'(v[63:30]), 64'(ptb));
      chk("fmt32", 64'h1, 64'(f32));
      chk("wide", 64'h1, 64'(wide));
      chk("shift keep", 64'h0, 64'(sh_o));
      chk("phys keep", 64'h0, 64'(pl_o));
      $display("format test done");
   endtask
   task automatic t_sign();
      logic [63:0] at[4] = '{64'h0000_0400_0000_0000,
         64'h0000_8000_0000_0000, 64'hffff_ffff_ffff_fff0,
         64'h0000_03ff_ffff_ffff};
      int sb;
      for (int w = 0; w < 2; w++) begin
         PIPE.req(0, SEL_ADDRESS_FORMAT_CONTROL, 64'(w * 2), q, t1);
         sb = w ? 47 : 42;
         foreach (at[i]) begin
            v = 64'($signed(at[i] << (63 - sb)) >>> (63 - sb));
            mem(at[i], 1'b0, 1'b0, 1'b0);
            chk("violation", 64'(v !== at[i]), 64'(avf));
         end
      end
      $display("sign check test done");
   endtask
   task automatic t_swap();
      logic [2:0] mk[4] = '{3'h7, 3'h6, 3'h4, 3'h0};
      PIPE.req(0, SEL_ADDRESS_FORMAT_CONTROL, 64'h1, q, t1);
      for (int s = 0; s < 4; s++) begin
         size = access_size_t'(s);
         pl_i = 3'h2;
         sh_i = 3'h3;
         mem(64'h0, 1'b0, 1'b0, 1'b0);
         chk("phys low", 64'(3'h2 ^ mk[s]), 64'(pl_o));
         chk("shift", 64'h4, 64'(sh_o));
      end
      $display("byte order test done");
   endtask
   initial begin
      mv = 1'b0;
      miss = 1'b0;
      flt = 1'b0;
      pte = 1'b0;
      repeat (2) @(posedge clk);
      #1;
      srst = 1'b0;
      chk("reset wide", 64'h0, 64'(wide));
      t_counter();
      t_fault();
      t_format();
      t_sign();
      t_swap();
      final_report();
   end
endmodule
